/* File: dv/iaa_ext_dev.sv */
`timescale 1ns/1ns
// far-side peripheral answering a forwarded acknowledge at its own level
module iaa_ext_dev (
	input wire logic clk, // system clock
	input wire logic sysRst, // async reset, high
	input wire logic extForward, // cycle on external bus
	input wire logic [23:0] ackAddr, // acknowledge address
	input wire logic [1:0] mode, // 0 silent, 1 vector, 2 autovector
	input wire logic slow, // answer late
	input wire logic [2:0] lvl, // own request level
	input wire logic [7:0] vec, // own vector
	output iaa_pkg::iaa_ext_t extPins // answer pins
);
	import iaa_pkg::*;
	logic [3:0] wt;
	// vector first, strobe a cycle later so the bus is settled when sampled
	always_ff @(posedge clk or posedge sysRst) begin
		if (sysRst) begin
			wt <= 4'h0;
			extPins <= '{1'b1, 1'b1, 8'h00};
		end else if (extForward && ackAddr[3:1] == lvl && mode != 2'h0) begin
			wt <= wt + 4'h1;
			if (wt == (slow ? 4'h9 : 4'h0))
				extPins.vec <= vec;
			if (wt == (slow ? 4'ha : 4'h1))
				extPins <= '{mode != 2'h1, mode != 2'h2, vec};
		end else begin
			wt <= 4'h0;
			// strobes rise to pull-ups; released data wanders, never holds
			extPins <= '{1'b1, 1'b1, ~extPins.vec};
		end
	end
endmodule

/* File: dv/iaa_top_tb.sv */
`timescale 1ns/1ns
// acknowledge sequences: corner cases plus random levels, ids and vectors
module iaa_top_tb;
	import iaa_pkg::*;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	iaa_regreq_t regReq = '0;
	iaa_modreq_t [NMOD-1:0] modReq = '0;
	iaa_ext_t extPins;
	logic [7:1] irqPinN = 7'h7f;
	logic ptReq = 1'b0;
	logic instrB = 1'b0;
	logic excDone = 1'b0;
	logic vecValid = 1'b0;
	logic [23:0] vecData = 24'h0;
	logic [15:0] regRdata, vbr;
	logic [23:0] ackAddr, vecAddr, pcOut;
	logic [2:0] fc, mask;
	logic ackCycle, extForward, bus_error_signal, intTerm, ptAck, stackStb, sup, trH, trL, vecFetch, handlerGo;
	logic [NMOD-1:0] modAck;
	logic [1:0] devMode = 2'h0;
	logic devSlow = 1'b0;
	logic [2:0] devLvl = 3'h0;
	logic [7:0] devVec = 8'h0;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;

	iaa_top DUT (.clk(clk), .sys_rst(sysRst), .regReq(regReq), .regRdata(regRdata),
		.irqPinN(irqPinN), .extPins(extPins), .modReq(modReq), .periodicTimerReq(ptReq),
		.instrBoundary(instrB), .excDone(excDone), .vecData(vecData), .vecValid(vecValid),
		.functionCodeLines(fc), .ackAddr(ackAddr), .ackCycle(ackCycle),
		.extForward(extForward), .busErrorSignal(bus_error_signal), .intTerminate(intTerm),
		.modAck(modAck), .periodicAck(ptAck), .stackStrobe(stackStb), .supervisor(sup),
		.traceBitHigh(trH), .traceBitLow(trL), .priorityMaskField(mask),
		.vecFetch(vecFetch), .vecAddr(vecAddr), .pcOut(pcOut), .handlerGo(handlerGo));

	iaa_ext_dev DEV (.clk(clk), .sysRst(sysRst), .extForward(extForward), .ackAddr(ackAddr),
		.mode(devMode), .slow(devSlow), .lvl(devLvl), .vec(devVec), .extPins(extPins));

	// 125 MHz system clock
	always #4 clk = ~clk;

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(string nm, logic [23:0] seen, logic [23:0] ex);
		tests_run++;
		if (seen !== ex) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	// expected vector table address and autovector number
	function automatic logic [23:0] expVecAddr(logic [15:0] b, logic [7:0] v);
		return {b, 8'h00} + {14'h0000, v, 2'b00};
	endfunction

	function automatic logic [7:0] expAuto(logic [2:0] l);
		return AUTO_VEC_BASE + {5'h00, l};
	endfunction

	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
		@(posedge clk) regReq <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdc(string nm, logic [3:0] a, logic [15:0] ex, logic [15:0] m);
		@(posedge clk) regReq <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk) regReq <= '0;
		#1;
		chk(nm, regRdata & m, ex);
	endtask

	task automatic quiet(string nm);
		logic s = 1'b0;
		repeat (20) begin
			@(posedge clk) #1;
			s |= ackCycle;
		end
		chk(nm, s, 1'b0);
		$display("quiet window %s done", nm);
	endtask

	// one full acknowledge: k[1] bus error expected, k[0] forwarded, w winner pulses
	task automatic runAck(logic [2:0] lvl, logic [7:0] ev, logic [1:0] k, logic [2:0] w);
		int n;
		logic s = 1'b0;
		logic b = 1'b0;
		logic e = 1'b0;
		logic i = 1'b0;
		logic [2:0] a = 3'h0;
		logic [23:0] pc = 24'($urandom);
		for (n = 0; n < 12 && ackCycle !== 1'b1; n++) begin
			@(posedge clk) #1;
			s |= stackStb;
		end
		chk("fc", fc, FC_CPU_SPACE);
		chk("addr", ackAddr, {ACK_ADDR_HI, lvl, 1'b1});
		chk("mask", mask, lvl);
		chk("status bits", {sup, trH, trL}, 3'h4);
		for (n = 0; n < 300 && vecFetch !== 1'b1; n++) begin
			@(posedge clk) #1;
			b |= bus_error_signal;
			e |= extForward;
			i |= intTerm;
			a |= {ptAck, modAck};
		end
		chk("stack", s, 1'b1);
		chk("bus_error_signal", b, k[1]);
		chk("forward", e, k[0]);
		chk("term", i, k == 2'h0);
		chk("winner", a, w);
		chk("vaddr", vecAddr, expVecAddr(vbr, ev));
		// sources drop their requests once acknowledged, so level 7 does not retrigger
		@(posedge clk) begin
			vecData <= pc;
			vecValid <= 1'b1;
			modReq <= '0;
			irqPinN <= 7'h7f;
			ptReq <= 1'b0;
		end
		@(posedge clk) vecValid <= 1'b0;
		#1;
		for (n = 0; n < 8 && handlerGo !== 1'b1; n++) @(posedge clk) #1;
		chk("pc", pcOut, pc);
		rdc("status", REG_STAT, {ev, 3'h0, 1'b0, k[1], lvl}, 16'hff1f);
		rdc("sr", REG_SR, {3'h1, 10'h000, lvl}, 16'hffff);
		$display("sequence at level %0d done", lvl);
	endtask

	initial begin
		logic [2:0] l;
		logic [3:0] ia, ib;
		logic [7:0] va, vb, pv;
		void'($urandom(32'ha183));
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;
		rdc("cfg", REG_CFG, 16'h000f, 16'hffff);
		rdc("unmapped", 4'hf, 16'h0000, 16'hffff);
		vbr = 16'($urandom);
		pv = 8'($urandom);
		va = 8'($urandom);
		vb = 8'($urandom);
		wr(REG_VBR, vbr);
		wr(REG_PTVEC, {8'h00, pv});
		wr(REG_CFG, 16'h030f);
		rdc("vbr", REG_VBR, vbr, 16'hffff);
		rdc("ptvec", REG_PTVEC, {8'h00, pv}, 16'hffff);
		// boundary open, so only the mask can hold the request off
		@(posedge clk) begin
			modReq[0] <= '{3'h5, va};
			instrB <= 1'b1;
		end
		quiet("masked");
		@(posedge clk) instrB <= 1'b0;
		wr(REG_SR, 16'hc000);
		quiet("no boundary");
		@(posedge clk) instrB <= 1'b1;
		runAck(3'h5, va, 2'h0, 3'h1);
		wr(REG_CFG, 16'h930f);
		wr(REG_SR, 16'hc007);
		@(posedge clk) begin
			instrB <= 1'b0;
			excDone <= 1'b1;
			modReq[1] <= '{3'h7, vb};
		end
		runAck(3'h7, vb, 2'h0, 3'h2);
		// random levels, distinct nonzero ids, both modules contending
		for (int t = 0; t < 3; t++) begin
			l = 3'($urandom_range(6, 1));
			ia = 4'($urandom_range(15, 1));
			ib = ia % 4'hf + 4'h1;
			va = 8'($urandom);
			vb = 8'($urandom);
			wr(REG_CFG, {ib, ia, 8'h0f});
			wr(REG_SR, 16'hc000);
			@(posedge clk) modReq <= '{'{l, vb}, '{l, va}};
			runAck(l, ia > ib ? va : vb, 2'h0, ia > ib ? 3'h1 : 3'h2);
		end
		wr(REG_CFG, 16'h000f);
		wr(REG_SR, 16'hc000);
		@(posedge clk) modReq[0] <= '{3'h3, va};
		runAck(3'h3, SPUR_VEC, 2'h2, 3'h0);
		// external device: vector, slow autovector, then silence
		for (int m = 0; m < 3; m++) begin
			wr(REG_SR, 16'hc000);
			@(posedge clk) begin
				devMode <= 2'((m + 1) % 3);
				devSlow <= m == 1;
				devLvl <= 3'h4;
				devVec <= va;
				irqPinN <= 7'h77;
			end
			vb = m == 0 ? va : (m == 1 ? expAuto(3'h4) : SPUR_VEC);
			runAck(3'h4, vb, m == 2 ? 2'h3 : 2'h1, 3'h0);
		end
		wr(REG_CFG, 16'h0902);
		wr(REG_SR, 16'hc000);
		@(posedge clk) begin
			modReq[0] <= '{3'h2, va};
			irqPinN <= 7'h7d;
			devMode <= 2'h1;
			devLvl <= 3'h2;
		end
		runAck(3'h2, va, 2'h0, 3'h1);
		wr(REG_CFG, 16'h000f);
		wr(REG_SR, 16'hc000);
		@(posedge clk) ptReq <= 1'b1;
		quiet("timer off");
		@(posedge clk) ptReq <= 1'b0;
		wr(REG_CFG, 16'h006f);
		@(posedge clk) begin
			ptReq <= 1'b1;
			irqPinN <= 7'h5f;
			devLvl <= 3'h6;
		end
		runAck(3'h6, pv, 2'h0, 3'h4);
		wrap_up();
	end
endmodule

/* File: rtl/iaa_pkg.sv */
package iaa_pkg;
	// clock and bus monitor timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int BUSMON_TIME_NS = 1000;
	// longest wait, so the division rounds down
	localparam int BUSMON_CYC = BUSMON_TIME_NS / CLK_PERIOD_NS;
	localparam int NMOD = 2;
	// register offsets
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_PTVEC = 4'h1;
	localparam logic [3:0] REG_VBR = 4'h2;
	localparam logic [3:0] REG_SR = 4'h3;
	localparam logic [3:0] REG_STAT = 4'h4;
	// field positions
	localparam int CFG_SIMID_LSB = 0;
	localparam int CFG_PTLVL_LSB = 4;
	localparam int CFG_MODID_LSB = 8;
	localparam int SR_MASK_LSB = 0;
	localparam int SR_SUP_BIT = 13;
	localparam int SR_T0_BIT = 14;
	localparam int SR_T1_BIT = 15;
	localparam int STAT_LVL_LSB = 0;
	localparam int STAT_SPUR_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_VEC_LSB = 8;
	// values after reset
	localparam logic [2:0] MASK_RST = 3'h7;
	localparam logic [3:0] SIM_ID_RST = 4'hf;
	localparam logic [3:0] MOD_ID_RST = 4'h0;
	localparam logic [2:0] PT_LVL_RST = 3'h0;
	localparam logic [7:0] PT_VEC_RST = 8'h40;
	localparam logic [15:0] VBR_RST = 16'h0000;
	// acknowledge cycle encodings
	localparam logic [2:0] FC_CPU_SPACE = 3'h7;
	localparam logic [19:0] ACK_ADDR_HI = 20'hfffff;
	localparam logic [2:0] LVL_NMI = 3'h7;
	localparam logic [3:0] ARB_NONE = 4'h0;
	localparam logic [7:0] SPUR_VEC = 8'h18;
	localparam logic [7:0] AUTO_VEC_BASE = 8'h18;
	typedef enum logic [2:0] {ST_IDLE, ST_STACK, ST_ACK, ST_ARB, ST_EXT, ST_FETCH, ST_WAITV} iaa_st_t;
	typedef struct packed {logic [2:0] level; logic [7:0] vector;} iaa_modreq_t;
	typedef struct packed {logic dataSizeAckN; logic autovectorRequestN; logic [7:0] vec;} iaa_ext_t;
	typedef struct packed {logic wr; logic rd; logic [3:0] addr; logic [15:0] wdata;} iaa_regreq_t;
	typedef struct packed {
		iaa_st_t st;
		logic [7:1] irqS1;
		logic [7:1] irqS2;
		iaa_ext_t extS1;
		iaa_ext_t extS2;
		logic [2:0] mask;
		logic sup;
		logic trHigh;
		logic trLow;
		logic [3:0] simId;
		logic [NMOD-1:0][3:0] modId;
		logic [2:0] ptLvl;
		logic [7:0] ptVec;
		logic [15:0] vbr;
		logic [2:0] lvl;
		logic [7:0] vec;
		logic spur;
		logic [7:0] tmo;
		logic [2:0] fc;
		logic [23:0] addr;
		logic ackCyc;
		logic extFwd;
		logic bus_error_signal;
		logic intTerm;
		logic [NMOD-1:0] modAck;
		logic ptAck;
		logic stackStb;
		logic vecFetch;
		logic [23:0] vecAddr;
		logic [23:0] pc;
		logic handlerGo;
		logic [15:0] rdata;
	} iaa_state_s_t;
endpackage

/* File: rtl/iaa_top.sv */
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - ignore levels at or below mask, except 7
// - drive level on address, start CPU-space read
// - copy acknowledged level into priority mask
// - sources answer only when level matches
// - highest 4-bit arbitration identifier wins
// - winning identifier zero gives spurious vector
// - system unit id resets 1111, others 0000
// - contention runs on every acknowledge
// - forward externally only when system unit wins
// - no contender ends cycle with bus error
// - internal winner supplies vector and termination
// - bus monitor timeout gives spurious exception
// - chip-select match only on forwarded cycles
// - periodic level zero disables periodic timer
// - periodic timer beats pins within system unit
// - start only at boundary or exception end
// - stack state, set supervisor, clear trace
// - function code lines read 111 during ack
// - address ones, level in 3:1, bit 0 set
// - autovector number derived from level
// - vector to address, load word into pc
module iaa_top (
	input wire logic clk, // system clock
	input wire logic sys_rst, // async reset, high
	input wire iaa_pkg::iaa_regreq_t regReq, // register request
	output logic [15:0] regRdata, // read data, next cycle
	input wire logic [7:1] irqPinN, // external request pins
	input wire iaa_pkg::iaa_ext_t extPins, // external answer pins
	input wire iaa_pkg::iaa_modreq_t [iaa_pkg::NMOD-1:0] modReq, // internal requests
	input wire logic periodicTimerReq, // periodic timer request
	input wire logic instrBoundary, // instruction boundary
	input wire logic excDone, // higher exception finished
	input wire logic [23:0] vecData, // vector table word
	input wire logic vecValid, // vector word valid
	output logic [2:0] functionCodeLines, // cycle space
	output logic [23:0] ackAddr, // acknowledge address
	output logic ackCycle, // acknowledge cycle active
	output logic extForward, // cycle on external bus
	output logic busErrorSignal, // bus error pulse
	output logic intTerminate, // internal termination
	output logic [iaa_pkg::NMOD-1:0] modAck, // module won
	output logic periodicAck, // periodic timer won
	output logic stackStrobe, // stack processor state
	output logic supervisor, // supervisor bit
	output logic traceBitHigh, // trace bit high
	output logic traceBitLow, // trace bit low
	output logic [2:0] priorityMaskField, // priority mask
	output logic vecFetch, // vector fetch pulse
	output logic [23:0] vecAddr, // vector address
	output logic [23:0] pcOut, // program counter
	output logic handlerGo // handler started
);
	import iaa_pkg::*;

	iaa_state_s_t s;
	iaa_state_s_t n;
	logic [7:1] reqVec;
	logic [2:0] top;
	logic rec;

	// periodic timer at a given level; zero level is off
	function automatic logic ptHits(input logic req, input logic [2:0] ptl,
		input logic [2:0] l);
		return req && (ptl != 3'h0) && (ptl == l);
	endfunction

	// one bit per level that some source requests
	function automatic logic [7:1] pendingLevels(input logic [7:1] pinsN,
		input iaa_modreq_t [NMOD-1:0] m, input logic ptr, input logic [2:0] ptl);
		logic [7:1] v;
		v = '0;
		for (int l = 1; l <= 7; l++) begin
			v[l] = !pinsN[l] || ptHits(ptr, ptl, 3'(l));
		end
		for (int i = 0; i < NMOD; i++) begin
			if (m[i].level != 3'h0) begin
				v[m[i].level] = 1'b1;
			end
		end
		return v;
	endfunction

	// highest requested level, zero when none
	function automatic logic [2:0] topLevel(input logic [7:1] v);
		logic [2:0] t;
		t = 3'h0;
		for (int l = 1; l <= 7; l++) begin
			if (v[l]) begin
				t = 3'(l);
			end
		end
		return t;
	endfunction

	// recognition against the mask; level 7 always passes
	assign reqVec = pendingLevels(s.irqS2, modReq, periodicTimerReq, s.ptLvl);
	assign top = topLevel(reqVec);
	assign rec = (top != 3'h0) && ((top > s.mask) || (top == LVL_NMI));

	// next-state logic for the whole block
	always_comb begin
		logic [3:0] best;
		logic simWon;
		logic simHas;
		int win;
		best = ARB_NONE;
		simWon = 1'b0;
		simHas = 1'b0;
		win = -1;
		n = s;
		// pins pass two flops before use
		n.irqS1 = irqPinN;
		n.irqS2 = s.irqS1;
		n.extS1 = extPins;
		n.extS2 = s.extS1;
		n.bus_error_signal = 1'b0;
		n.intTerm = 1'b0;
		n.modAck = '0;
		n.ptAck = 1'b0;
		n.stackStb = 1'b0;
		n.vecFetch = 1'b0;
		n.handlerGo = 1'b0;
		n.rdata = '0;
		// register writes; the sequencer below may override
		if (regReq.wr) begin
			case (regReq.addr)
				REG_CFG: begin
					n.simId = regReq.wdata[CFG_SIMID_LSB +: 4];
					n.ptLvl = regReq.wdata[CFG_PTLVL_LSB +: 3];
					for (int i = 0; i < NMOD; i++) begin
						n.modId[i] = regReq.wdata[CFG_MODID_LSB + 4 * i +: 4];
					end
				end
				REG_PTVEC: n.ptVec = regReq.wdata[7:0];
				REG_VBR: n.vbr = regReq.wdata;
				REG_SR: begin
					n.mask = regReq.wdata[SR_MASK_LSB +: 3];
					n.sup = regReq.wdata[SR_SUP_BIT];
					n.trLow = regReq.wdata[SR_T0_BIT];
					n.trHigh = regReq.wdata[SR_T1_BIT];
				end
				default: ;
			endcase
		end
		// register reads; unmapped offsets read zero
		if (regReq.rd) begin
			case (regReq.addr)
				REG_CFG: begin
					n.rdata[CFG_SIMID_LSB +: 4] = s.simId;
					n.rdata[CFG_PTLVL_LSB +: 3] = s.ptLvl;
					for (int i = 0; i < NMOD; i++) begin
						n.rdata[CFG_MODID_LSB + 4 * i +: 4] = s.modId[i];
					end
				end
				REG_PTVEC: n.rdata[7:0] = s.ptVec;
				REG_VBR: n.rdata = s.vbr;
				REG_SR: begin
					n.rdata[SR_MASK_LSB +: 3] = s.mask;
					n.rdata[SR_SUP_BIT] = s.sup;
					n.rdata[SR_T0_BIT] = s.trLow;
					n.rdata[SR_T1_BIT] = s.trHigh;
				end
				REG_STAT: begin
					n.rdata[STAT_LVL_LSB +: 3] = s.lvl;
					n.rdata[STAT_SPUR_BIT] = s.spur;
					n.rdata[STAT_BUSY_BIT] = (s.st != ST_IDLE);
					n.rdata[STAT_VEC_LSB +: 8] = s.vec;
				end
				default: ;
			endcase
		end
		// acknowledge sequencer
		case (s.st)
			ST_IDLE: begin
				// pending requests wait for a safe point
				if (rec && (instrBoundary || excDone)) begin
					n.lvl = top;
					n.st = ST_STACK;
				end
			end
			ST_STACK: begin
				n.stackStb = 1'b1;
				n.sup = 1'b1;
				n.trHigh = 1'b0;
				n.trLow = 1'b0;
				n.st = ST_ACK;
			end
			ST_ACK: begin
				n.fc = FC_CPU_SPACE;
				n.addr = {ACK_ADDR_HI, s.lvl, 1'b1};
				n.ackCyc = 1'b1;
				n.mask = s.lvl;
				n.st = ST_ARB;
			end
			ST_ARB: begin
				// contention always runs, even with one source
				simHas = !s.irqS2[s.lvl] || ptHits(periodicTimerReq, s.ptLvl, s.lvl);
				if (simHas) begin
					simWon = 1'b1;
					best = s.simId;
				end
				// only sources at the acknowledged level contend
				for (int i = 0; i < NMOD; i++) begin
					if (modReq[i].level == s.lvl && s.modId[i] > best) begin
						best = s.modId[i];
						win = i;
						simWon = 1'b0;
					end
				end
				if (best == ARB_NONE) begin
					// nobody or only identifier zero
					n.bus_error_signal = 1'b1;
					n.vec = SPUR_VEC;
					n.spur = 1'b1;
					n.st = ST_FETCH;
				end else if (!simWon) begin
					n.modAck[win] = 1'b1;
					n.intTerm = 1'b1;
					n.vec = modReq[win].vector;
					n.spur = 1'b0;
					n.st = ST_FETCH;
				end else if (ptHits(periodicTimerReq, s.ptLvl, s.lvl)) begin
					// timer served before the pins
					n.ptAck = 1'b1;
					n.intTerm = 1'b1;
					n.vec = s.ptVec;
					n.spur = 1'b0;
					n.st = ST_FETCH;
				end else begin
					// chip-select match is enabled by this forward
					n.extFwd = 1'b1;
					n.tmo = '0;
					n.st = ST_EXT;
				end
			end
			ST_EXT: begin
				// device answers with a vector or an autovector
				if (!s.extS2.dataSizeAckN) begin
					n.vec = s.extS2.vec;
					n.spur = 1'b0;
					n.extFwd = 1'b0;
					n.st = ST_FETCH;
				end else if (!s.extS2.autovectorRequestN) begin
					n.vec = AUTO_VEC_BASE + {5'h00, s.lvl};
					n.spur = 1'b0;
					n.extFwd = 1'b0;
					n.st = ST_FETCH;
				end else if (s.tmo == 8'(BUSMON_CYC - 1)) begin
					n.bus_error_signal = 1'b1;
					n.vec = SPUR_VEC;
					n.spur = 1'b1;
					n.extFwd = 1'b0;
					n.st = ST_FETCH;
				end else begin
					n.tmo = s.tmo + 8'h01;
				end
			end
			ST_FETCH: begin
				// end of acknowledge; table index is vector times four
				n.ackCyc = 1'b0;
				n.fc = 3'h0;
				n.addr = '0;
				n.vecFetch = 1'b1;
				n.vecAddr = {s.vbr, 8'h00} + {14'h0000, s.vec, 2'b00};
				n.st = ST_WAITV;
			end
			ST_WAITV: begin
				// memory latency is open-ended, so no timeout here
				if (vecValid) begin
					n.pc = vecData;
					n.handlerGo = 1'b1;
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase
	end

	// one register stage for all state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.irqS1 <= '1;
			s.irqS2 <= '1;
			s.extS1 <= '1;
			s.extS2 <= '1;
			s.mask <= MASK_RST;
			s.sup <= 1'b1;
			s.simId <= SIM_ID_RST;
			s.modId <= {NMOD{MOD_ID_RST}};
			s.ptLvl <= PT_LVL_RST;
			s.ptVec <= PT_VEC_RST;
			s.vbr <= VBR_RST;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state flops
	assign regRdata = s.rdata;
	assign functionCodeLines = s.fc;
	assign ackAddr = s.addr;
	assign ackCycle = s.ackCyc;
	assign extForward = s.extFwd;
	assign busErrorSignal = s.bus_error_signal;
	assign intTerminate = s.intTerm;
	assign modAck = s.modAck;
	assign periodicAck = s.ptAck;
	assign stackStrobe = s.stackStb;
	assign supervisor = s.sup;
	assign traceBitHigh = s.trHigh;
	assign traceBitLow = s.trLow;
	assign priorityMaskField = s.mask;
	assign vecFetch = s.vecFetch;
	assign vecAddr = s.vecAddr;
	assign pcOut = s.pc;
	assign handlerGo = s.handlerGo;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// checks on the sequencer
	chk_mask_blocks: assert property (
		(s.st == ST_IDLE && !rec) |=> (s.st == ST_IDLE))
		else $error("masked request started acknowledge");
	chk_ack_addr: assert property (
		s.ackCyc |-> (s.addr[23:4] == 20'hfffff && s.addr[3:1] == s.lvl && s.addr[0]))
		else $error("bad acknowledge address");
	chk_fc_space: assert property (
		s.ackCyc |-> (s.fc == 3'h7))
		else $error("function code not cpu space");
	chk_mask_copy: assert property (
		(s.st == ST_ACK) |=> (s.mask == $past(s.lvl) && s.ackCyc))
		else $error("mask not loaded with level");
	chk_stack_first: assert property (
		s.stackStb |-> (s.sup && !s.trHigh && !s.trLow) ##1 s.ackCyc)
		else $error("stacking order wrong");
	chk_spur_vector: assert property (
		s.bus_error_signal |-> (s.vec == 8'h18 && s.spur) ##1 s.vecFetch)
		else $error("bus error without spurious vector");
	chk_fwd_in_ack: assert property (
		s.extFwd |-> (s.ackCyc && s.st == ST_EXT))
		else $error("forward outside acknowledge");
	chk_bus_timeout: assert property (
		(s.st == ST_EXT && s.tmo == 8'(BUSMON_CYC - 1) && s.extS2.dataSizeAckN
		&& s.extS2.autovectorRequestN) |=> (s.bus_error_signal && !s.extFwd))
		else $error("bus monitor did not fire");
	chk_pt_off: assert property (
		(s.ptLvl == 3'h0) |=> !s.ptAck)
		else $error("periodic ack while disabled");
	chk_pc_load: assert property (
		s.handlerGo |-> (s.pc == $past(vecData) && s.st == ST_IDLE))
		else $error("pc not loaded from vector");
	// nonmaskable level starts at a safe point even under mask seven
	chk_nmi_starts: assert property (
		(s.st == ST_IDLE && top == LVL_NMI && (instrBoundary || excDone))
		|=> (s.st == ST_STACK))
		else $error("level seven not recognised");
	// arbitration never leaves the cycle without an outcome
	chk_arb_resolves: assert property (
		(s.st == ST_ARB) |=> (s.bus_error_signal || s.intTerm || s.extFwd))
		else $error("arbitration left the cycle open");
	chk_internal_term: assert property (
		(s.modAck != '0) |-> (s.intTerm && !s.extFwd))
		else $error("internal winner without termination");
	chk_auto_number: assert property (
		(s.st == ST_EXT && s.extS2.dataSizeAckN && !s.extS2.autovectorRequestN)
		|=> (s.vec == AUTO_VEC_BASE + {5'h00, s.lvl}))
		else $error("autovector number wrong");
endmodule
